// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import tpd_pkg::*;
    typedef struct {
        logic [6:0]  coarse;
        logic        pol;
        logic [31:0] exp_high;
    } tpd_row_s;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tuning_pwm_output;
    logic        clear   = 1'b0;
    logic [31:0] high_cnt;
    logic [31:0] rise_cnt;
    logic [31:0] min_w;
    logic [31:0] max_w;
    int          miscompares     = 0;
    int          samples_checked = 0;
    // high clocks in one 384-clock window: 3*(127-coarse), inverted at pol 0
    tpd_row_s    rows [6] = '{'{7'h00, 1'b1, 32'h17d}, '{7'h7f, 1'b1, 32'h000},
                              '{7'h40, 1'b1, 32'h0bd}, '{7'h7e, 1'b1, 32'h003},
                              '{7'h1d, 1'b0, 32'h05a}, '{7'h01, 1'b0, 32'h006}};

    always #25 pclk = ~pclk;

    tpd_top u_tpd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tuning_pwm_output(tuning_pwm_output));

    tpd_rc_model u_tpd_rc_model (.pclk(pclk), .clear(clear), .pwm_in(tuning_pwm_output),
        .high_cnt(high_cnt), .rise_cnt(rise_cnt), .min_w(min_w), .max_w(max_w));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("pready", 32'h1, {31'h0, pready});
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, wdata, d, e);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] addr,
                          input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b0, addr, 32'h0, d, e);
        chk(what, exp, d);
        chk(what, {31'h0, exp_err}, {31'h0, e});
    endtask

    task automatic measure(input int clocks);
        @(posedge pclk);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        repeat (clocks) @(posedge pclk);
        #1;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic        e;
        int          n;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("coarse rst", TPD_COARSE_OFS, 32'h00, 1'b0);
        rd_chk("fine rst", TPD_FINE_OFS, 32'h7f, 1'b0);
        rd_chk("ctrl rst", TPD_CTRL_OFS, 32'h01, 1'b0);
        rd_chk("work rst", TPD_WORK_OFS, 32'h7f, 1'b0);
        rd_chk("unmapped rd", 12'h014, 32'h00, 1'b1);
        apb(1'b1, 12'h014, 32'h55, d, e);
        chk("unmapped wr", 32'h1, {31'h0, e});
        wr(TPD_WORK_OFS, 32'h1234);
        rd_chk("work ro", TPD_WORK_OFS, 32'h7f, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(TPD_CTRL_OFS, {31'h0, rows[i].pol});
            wr(TPD_COARSE_OFS, {25'h0, rows[i].coarse});
            wr(TPD_FINE_OFS, 32'h7f);
            repeat (1152) @(posedge pclk);
            measure(384);
            chk("coarse high", rows[i].exp_high, high_cnt);
        end
        // coarse 7f leaves only the extra ticks; zero bits 0,2,4,6 give 85
        wr(TPD_CTRL_OFS, 32'h1);
        wr(TPD_COARSE_OFS, 32'h7f);
        wr(TPD_FINE_OFS, 32'h2a);
        repeat (1152) @(posedge pclk);
        measure(49152);
        chk("extra count", 32'h55, rise_cnt);
        chk("extra high", 32'hff, high_cnt);
        chk("extra min", 32'h3, min_w);
        chk("extra max", 32'h3, max_w);
        // inverted polarity while odd extras still drive the pin
        wr(TPD_CTRL_OFS, 32'h0);
        repeat (800) @(posedge pclk);
        wr(TPD_CTRL_OFS, 32'h1);
        wr(TPD_FINE_OFS, 32'h7f);
        repeat (1152) @(posedge pclk);
        // a coarse write alone must not reach the working latch
        wr(TPD_COARSE_OFS, 32'h00);
        measure(800);
        chk("coarse alone", 32'h0, high_cnt);
        rd_chk("work held", TPD_WORK_OFS, 32'h3fff, 1'b0);
        rd_chk("status idle", TPD_STATUS_OFS, 32'h0, 1'b0);
        wr(TPD_FINE_OFS, 32'h7f);
        n = 0;
        while (tuning_pwm_output !== 1'b1 && n < 800) begin
            @(posedge pclk);
            n++;
        end
        chk("load early", 32'h1, {31'h0, n >= 360});
        chk("load late", 32'h1, {31'h0, n < 790});
        rd_chk("work new", TPD_WORK_OFS, 32'h7f, 1'b0);
        wr(TPD_CTRL_OFS, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk("rst out", 32'h0, {31'h0, tuning_pwm_output});
        chk("rst ready", 32'h0, {31'h0, pready});
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl rst2", TPD_CTRL_OFS, 32'h01, 1'b0);
        rd_chk("coarse rst2", TPD_COARSE_OFS, 32'h00, 1'b0);
        stop_test();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
endmodule // testbench

// *** tpd_pkg.sv ***
package tpd_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] TPD_COARSE_OFS    = 12'h000;
    localparam logic [11:0] TPD_FINE_OFS      = 12'h004;
    localparam logic [11:0] TPD_CTRL_OFS      = 12'h008;
    localparam logic [11:0] TPD_WORK_OFS      = 12'h00c;
    localparam logic [11:0] TPD_STATUS_OFS    = 12'h010;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int          TPD_CTRL_POL_BIT  = 0;
    localparam int          TPD_STAT_PEND_BIT = 0;
    localparam int          TPD_STAT_OUT_BIT  = 1;
    localparam logic [6:0]  TPD_COARSE_RST    = 7'h00;
    localparam logic [6:0]  TPD_FINE_RST      = 7'h7f;
    localparam logic        TPD_POL_RST       = 1'b1;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          TPD_TICK_DIV      = 3;
    localparam int          TPD_CNT_W         = 14;
    localparam int          TPD_HALF_W        = 7;

    typedef struct packed {
        logic [6:0] coarse;
        logic [6:0] fine;
    } tpd_value_s;

endpackage

// *** tpd_rc_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// integrator at the tuning pin, reduced to counts over a window
// ************************************************************
// the average level is high_cnt over the window length; pulse widths
// are kept so that single-tick extras can be told from coarse pulses
module tpd_rc_model (
    input  wire logic        pclk,
    input  wire logic        clear,
    input  wire logic        pwm_in,
    output logic      [31:0] high_cnt,
    output logic      [31:0] rise_cnt,
    output logic      [31:0] min_w,
    output logic      [31:0] max_w
);
    logic        last_ff = 1'b0;
    logic        seen_ff = 1'b0;
    logic [31:0] run_ff  = 32'h0;

    always_ff @(posedge pclk) begin
        if (clear) begin
            high_cnt <= 32'h0;
            rise_cnt <= 32'h0;
            min_w    <= 32'hffffffff;
            max_w    <= 32'h0;
            seen_ff  <= 1'b0;
            run_ff   <= 32'h0;
        end else begin
            high_cnt <= high_cnt + {31'h0, pwm_in};
            run_ff   <= pwm_in ? run_ff + 32'h1 : 32'h0;
            if (pwm_in && !last_ff) begin
                rise_cnt <= rise_cnt + 32'h1;
                seen_ff  <= 1'b1;
            end
            // a pulse cut by the window start has no rise and is not measured
            if (!pwm_in && last_ff && seen_ff) begin
                if (run_ff < min_w) min_w <= run_ff;
                if (run_ff > max_w) max_w <= run_ff;
            end
        end
        last_ff <= pwm_in;
    end
endmodule // tpd_rc_model

// *** tpd_tick_div.sv ***
`timescale 1ns/1ns
module tpd_tick_div
    import tpd_pkg::*;
#(
    parameter int DIV = TPD_TICK_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         tick_ff;
    logic         nxt_tick;

    // refused at elaboration: a zero divider has no tick at all
    if (DIV < 1) begin : g_bad_div
        $error("tick divider must be at least one");
    end

    always_comb begin
        if (cnt_ff == W'(DIV - 1)) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt  = cnt_ff + W'(1);
            nxt_tick = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_ff |=> !tick_ff) else $error("tick pulse longer than one cycle");
endmodule // tpd_tick_div

// *** tpd_top.sv ***
`timescale 1ns/1ns
module tpd_top
    import tpd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tuning_pwm_output
);
    // ************************************************************
    // tick and free counter
    // ************************************************************
    logic                 tick;
    logic [TPD_CNT_W-1:0] cnt_ff;
    logic [TPD_CNT_W-1:0] nxt_cnt;

    tpd_tick_div #(
        .DIV     (TPD_TICK_DIV)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    always_comb begin
        nxt_cnt = tick ? cnt_ff + TPD_CNT_W'(1) : cnt_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    logic [6:0] phase;
    logic [6:0] sub_num;
    logic       sub_start;
    assign phase     = cnt_ff[TPD_HALF_W-1:0];
    assign sub_num   = cnt_ff[TPD_CNT_W-1:TPD_HALF_W];
    // tick that moves the counter to phase 0: the last tick of a sub-period
    assign sub_start = tick && (phase == 7'h7f);

    // ************************************************************
    // register bus and latches
    // ************************************************************
    logic [6:0]  coarse_tuning_latch_ff, nxt_coarse;
    logic [6:0]  fine_tuning_latch_ff, nxt_fine;
    logic        tuning_polarity_bit_ff, nxt_pol;
    logic        pend_ff, nxt_pend;
    tpd_value_s  work_ff, nxt_work;
    tpd_value_s  stage_ff, nxt_stage;
    logic        arm_ff, nxt_arm;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic        tuning_pwm_output_ff;

    assign wr_en = psel && penable && pwrite && pready_ff;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        hit = (paddr == TPD_COARSE_OFS) || (paddr == TPD_FINE_OFS)
           || (paddr == TPD_CTRL_OFS) || (paddr == TPD_WORK_OFS)
           || (paddr == TPD_STATUS_OFS);
    end

    always_comb begin
        nxt_coarse  = coarse_tuning_latch_ff;
        nxt_fine    = fine_tuning_latch_ff;
        nxt_pol     = tuning_polarity_bit_ff;
        nxt_pend    = pend_ff;
        nxt_work    = work_ff;
        nxt_stage   = stage_ff;
        nxt_arm     = arm_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        // no wait state: answer in the cycle after setup
        if (psel && !penable) begin
            nxt_pready  = 1'b1;
            nxt_pslverr = !hit;
        end
        if (rd_en) begin
            unique case (paddr)
                TPD_COARSE_OFS: nxt_prdata = {25'h0, coarse_tuning_latch_ff};
                TPD_FINE_OFS:   nxt_prdata = {25'h0, fine_tuning_latch_ff};
                TPD_CTRL_OFS:   nxt_prdata = {31'h0, tuning_polarity_bit_ff};
                TPD_WORK_OFS:   nxt_prdata = {18'h0, work_ff};
                TPD_STATUS_OFS: nxt_prdata = {30'h0, tuning_pwm_output_ff, pend_ff};
                default:        nxt_prdata = 32'h0;
            endcase
        end
        // the new value drives the waveform one sub-period after loading
        if (sub_start) begin
            nxt_arm = 1'b0;
            if (arm_ff) begin
                nxt_stage = work_ff;
            end
        end
        if (sub_start && pend_ff) begin
            nxt_work = '{coarse: coarse_tuning_latch_ff, fine: fine_tuning_latch_ff};
            nxt_pend = 1'b0;
            nxt_arm  = 1'b1;
        end
        if (wr_en && hit) begin
            unique case (paddr)
                // coarse first, then fine; only the fine write arms the transfer
                TPD_COARSE_OFS: nxt_coarse = pwdata[6:0];
                TPD_FINE_OFS: begin
                    nxt_fine = pwdata[6:0];
                    nxt_pend = 1'b1;
                end
                TPD_CTRL_OFS:   nxt_pol = pwdata[TPD_CTRL_POL_BIT];
                default:        ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_tuning_latch_ff <= TPD_COARSE_RST;
            fine_tuning_latch_ff   <= TPD_FINE_RST;
            tuning_polarity_bit_ff <= TPD_POL_RST;
            pend_ff                <= 1'b0;
            work_ff                <= '{coarse: TPD_COARSE_RST, fine: TPD_FINE_RST};
            stage_ff               <= '{coarse: TPD_COARSE_RST, fine: TPD_FINE_RST};
            arm_ff                 <= 1'b0;
            prdata_ff              <= 32'h0;
            pready_ff              <= 1'b0;
            pslverr_ff             <= 1'b0;
        end else begin
            coarse_tuning_latch_ff <= nxt_coarse;
            fine_tuning_latch_ff   <= nxt_fine;
            tuning_polarity_bit_ff <= nxt_pol;
            pend_ff                <= nxt_pend;
            work_ff                <= nxt_work;
            stage_ff               <= nxt_stage;
            arm_ff                 <= nxt_arm;
            prdata_ff              <= nxt_prdata;
            pready_ff              <= nxt_pready;
            pslverr_ff             <= nxt_pslverr;
        end
    end

    // ************************************************************
    // waveform
    // ************************************************************
    tpd_wave u_wave (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .sub_num  (sub_num),
        .phase    (phase),
        .work     (stage_ff),
        .polarity (tuning_polarity_bit_ff),
        .wave     (tuning_pwm_output_ff)
    );

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign tuning_pwm_output = tuning_pwm_output_ff;

    // ************************************************************
    // checks
    // ************************************************************
    counter_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> cnt_ff == $past(cnt_ff) + TPD_CNT_W'(1))
        else $error("counter did not advance on tick");

    counter_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tick |=> $stable(cnt_ff)) else $error("counter moved without tick");

    sequence fine_written_s;
        wr_en && (paddr == TPD_FINE_OFS);
    endsequence

    pend_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        fine_written_s |=> pend_ff) else $error("fine write did not arm transfer");

    work_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        sub_start && pend_ff && !wr_en |=> !pend_ff
        && work_ff == {$past(coarse_tuning_latch_ff), $past(fine_tuning_latch_ff)})
        else $error("working latch not loaded at sub-period start");

    work_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sub_start |=> $stable(work_ff)) else $error("working latch changed mid period");

    stage_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        sub_start && arm_ff |=> stage_ff == $past(work_ff))
        else $error("staged value late");

    coarse_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && phase == 7'h00 && stage_ff.fine == 7'h7f && tuning_polarity_bit_ff
        |=> !tuning_pwm_output_ff) else $error("coarse pulse high at period start");

    extra_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && phase == 7'h00 && sub_num == 7'h40 && !stage_ff.fine[0]
        && tuning_polarity_bit_ff |=> tuning_pwm_output_ff)
        else $error("extra pulse missing at sub-period 64");

    odd_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && phase == 7'h00 && sub_num[0] && !stage_ff.fine[6]
        && !tuning_polarity_bit_ff |=> !tuning_pwm_output_ff)
        else $error("odd sub-period pulse missing");

    pol_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && phase == 7'h7f && stage_ff.coarse != 7'h7f && !tuning_polarity_bit_ff
        |=> !tuning_pwm_output_ff) else $error("inverted polarity not applied");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready_ff) else $error("no answer after setup");
endmodule // tpd_top

// *** tpd_wave.sv ***
`timescale 1ns/1ns
module tpd_wave
    import tpd_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic [6:0] sub_num,
    input  wire logic [6:0] phase,
    input  wire tpd_value_s work,
    input  wire logic       polarity,
    output logic            wave
);
    // ************************************************************
    // fine selection
    // ************************************************************
    function automatic logic fine_hit(input logic [6:0] fine, input logic [6:0] sub);
        logic hit;
        hit = 1'b0;
        for (int b = 0; b < 7; b++) begin
            // bit b picks sub-periods whose lowest set bit is 6-b
            if (!fine[b] && sub[6-b] && ((sub & 7'((1 << (6 - b)) - 1)) == 7'h00)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic wave_ff;
    logic nxt_wave;
    logic coarse_hi;
    logic extra;

    always_comb begin
        coarse_hi = (phase > work.coarse);
        extra     = (phase == 7'h00) && fine_hit(work.fine, sub_num);
        nxt_wave  = (coarse_hi | extra) ~^ polarity;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_ff <= 1'b0;
        end else if (tick) begin
            wave_ff <= nxt_wave;
        end
    end

    assign wave = wave_ff;
endmodule // tpd_wave
